// [common/rda_cfg.svh]
// Register indices, bit positions, reset values and timing figures.
`ifndef RDA_CFG_SVH
`define RDA_CFG_SVH

// Register indices on the plain register port.
`define RDA_REG_TIMING 3'h0
`define RDA_REG_MODEM 3'h1
`define RDA_REG_ANSWER 3'h2
`define RDA_REG_CTRL 3'h3
`define RDA_REG_STATUS 3'h4
`define RDA_REG_IRQ_STAT 3'h5
`define RDA_REG_IRQ_CLR 3'h6
`define RDA_REG_IRQ_EN 3'h7

// Reset values.
`define RDA_SW_RST 8'h00
`define RDA_CTRL_RST 8'h08

// Control register bit positions.
`define RDA_CTRL_AUTO 0
`define RDA_CTRL_REGION 1
`define RDA_CTRL_PBX 2
`define RDA_CTRL_LIMIT 3
`define RDA_CTRL_DELAY_LSB 4

// Interrupt event bit positions.
`define RDA_EV_ACK 0
`define RDA_EV_COUNT 1
`define RDA_EV_ANSWER 2
`define RDA_EV_TIMEOUT 3
`define RDA_EV_W 4

// Clock rate and the two tick rates.
`define RDA_CLK_HZ 50000000
`define RDA_FINE_HZ 10000
`define RDA_MS_HZ 1000

// Millisecond timer width and the off and detecting figures in ms.
`define RDA_MS_W 14
`define RDA_MIN_OFF_0 14'd1500
`define RDA_MIN_OFF_1 14'd500
`define RDA_MIN_OFF_2 14'd700
`define RDA_MIN_OFF_3 14'd900
`define RDA_MAX_OFF_0 14'd6000
`define RDA_MAX_OFF_1 14'd7000
`define RDA_MAX_OFF_2 14'd9000
`define RDA_MAX_OFF_3 14'd11000
`define RDA_DET_0 14'd800
`define RDA_DET_1 14'd200
`define RDA_DET_2 14'd250
`define RDA_DET_3 14'd150

// Ring frequency limits in Hz; periods are counted in fine ticks.
`define RDA_PER_W 12
`define RDA_LO_HZ_0 13
`define RDA_LO_HZ_1 15
`define RDA_LO_HZ_2 23
`define RDA_LO_HZ_3 20
`define RDA_LO_HZ_FIX 32
`define RDA_HI_HZ_0 30
`define RDA_HI_HZ_1 55
`define RDA_HI_HZ_2 70
`define RDA_HI_HZ_3 200
`define RDA_PER(hz) (`RDA_FINE_HZ / (hz))

// Attenuation cap applied while the limit switch reads 0.
`define RDA_ATTEN_CAP 4'h8

`endif

// [common/rda_pkg.sv]
// Types shared by the ring detector modules.
package rda_pkg;

   typedef struct packed
   {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rda_req_t;

   typedef struct packed
   {
      logic [1:0] equalizer;
      logic [1:0] rx_level;
      logic [3:0] tx_atten;
   } rda_modem_t;

endpackage

// [verilog/rda_tick.sv]
// Fine and millisecond tick generator.
`timescale 1ns/1ps
`default_nettype none
module rda_tick
#(
   parameter int FINE_DIV = 5000,
   parameter int MS_DIV = 10
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Ticks.
   output logic fine_tick,
   output logic ms_tick
);

   logic [15:0] div_q;
   logic [7:0] ms_div_q;
   wire div_end = (div_q == 16'(FINE_DIV - 1));
   wire ms_end = (ms_div_q == 8'(MS_DIV - 1));

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_q <= 16'h0000;
         ms_div_q <= 8'h00;
         fine_tick <= 1'b0;
         ms_tick <= 1'b0;
      end
      else
      begin
         div_q <= div_end ? 16'h0000 : div_q + 16'h0001;
         if (div_end)
            ms_div_q <= ms_end ? 8'h00 : ms_div_q + 8'h01;
         fine_tick <= div_end;
         ms_tick <= div_end & ms_end;
      end
   end

endmodule // rda_tick
`default_nettype wire

// [verilog/rda_top.sv]
// Ring detection, auto-answer ring counting and modem setting decode.
//
// Contract
// - Minimum off-time field: 00=1500, 01=500, 10=700, 11=900 ms.
// - Maximum off-time field: 00=6, 01=7, 10=9, 11=11 s.
// - A gap counts as off only between the minimum and maximum off times.
// - Detecting-time field: 00=800, 01=200, 10=250, 11=150 ms.
// - Unbroken in-band ringing for the detecting time acknowledges a call.
// - Lower limit 13/15/23/20 Hz; upper limit 30/55/70/200 Hz.
// - Override with exchange off forces a 32 Hz lower limit; readback kept.
// - Ring-count field gives fixed counts or allowed ranges per code.
// - Cable equalizer code goes to the modem: 0, 1.8, 3.6, 5.6 km.
// - Reception level code goes to the modem: -43, -47, -49, -51 dBm.
// - Transmit attenuation is the sum of 8, 4, 2, 1 dB steps.
// - Attenuation is restricted while the limit switch reads 0.
`timescale 1ns/1ps
`default_nettype none
`include "rda_cfg.svh"
module rda_top
#(
   parameter int FINE_DIV = `RDA_CLK_HZ / `RDA_FINE_HZ,
   parameter int MS_DIV = `RDA_FINE_HZ / `RDA_MS_HZ
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register port.
   input wire rda_pkg::rda_req_t bus_req,
   output logic [7:0] bus_rdata,
   // Line interface.
   input wire logic ring_signal,
   // Modem front end.
   output rda_pkg::rda_modem_t modem_cfg,
   // Call handling.
   output logic automatic_answer,
   output logic [3:0] ring_count,
   output logic irq
);

   import rda_pkg::*;

   // Decoders shared by the live logic.
   function automatic logic [`RDA_MS_W-1:0] dec_min_off(input logic [1:0] f);
      unique case (f)
         2'b00: dec_min_off = `RDA_MIN_OFF_0;
         2'b01: dec_min_off = `RDA_MIN_OFF_1;
         2'b10: dec_min_off = `RDA_MIN_OFF_2;
         2'b11: dec_min_off = `RDA_MIN_OFF_3;
      endcase
   endfunction

   function automatic logic [`RDA_MS_W-1:0] dec_max_off(input logic [1:0] f);
      unique case (f)
         2'b00: dec_max_off = `RDA_MAX_OFF_0;
         2'b01: dec_max_off = `RDA_MAX_OFF_1;
         2'b10: dec_max_off = `RDA_MAX_OFF_2;
         2'b11: dec_max_off = `RDA_MAX_OFF_3;
      endcase
   endfunction

   function automatic logic [`RDA_MS_W-1:0] dec_det(input logic [1:0] f);
      unique case (f)
         2'b00: dec_det = `RDA_DET_0;
         2'b01: dec_det = `RDA_DET_1;
         2'b10: dec_det = `RDA_DET_2;
         2'b11: dec_det = `RDA_DET_3;
      endcase
   endfunction

   // The lowest frequency gives the longest allowed period.
   function automatic logic [`RDA_PER_W-1:0] dec_per_max(input logic [1:0] f,
                                                        input logic fix);
      if (fix)
         dec_per_max = `RDA_PER_W'(`RDA_PER(`RDA_LO_HZ_FIX));
      else
         unique case (f)
            2'b00: dec_per_max = `RDA_PER_W'(`RDA_PER(`RDA_LO_HZ_0));
            2'b01: dec_per_max = `RDA_PER_W'(`RDA_PER(`RDA_LO_HZ_1));
            2'b10: dec_per_max = `RDA_PER_W'(`RDA_PER(`RDA_LO_HZ_2));
            2'b11: dec_per_max = `RDA_PER_W'(`RDA_PER(`RDA_LO_HZ_3));
         endcase
   endfunction

   function automatic logic [`RDA_PER_W-1:0] dec_per_min(input logic [1:0] f);
      unique case (f)
         2'b00: dec_per_min = `RDA_PER_W'(`RDA_PER(`RDA_HI_HZ_0));
         2'b01: dec_per_min = `RDA_PER_W'(`RDA_PER(`RDA_HI_HZ_1));
         2'b10: dec_per_min = `RDA_PER_W'(`RDA_PER(`RDA_HI_HZ_2));
         2'b11: dec_per_min = `RDA_PER_W'(`RDA_PER(`RDA_HI_HZ_3));
      endcase
   endfunction

   // Ring-count code to {lowest, highest} allowed count.
   function automatic logic [7:0] dec_rings(input logic [3:0] f);
      if (f[3:2] == 2'b00)
         dec_rings = {f + 4'h1, f + 4'h1};
      else if (f[3:2] == 2'b01)
         dec_rings = {4'h1, f - 4'h2};
      else if (f[3:2] == 2'b10)
         dec_rings = {4'h2, f - 4'h5};
      else
         unique case (f[1:0])
            2'b00: dec_rings = {4'h1, 4'ha};
            2'b01: dec_rings = {4'h2, 4'ha};
            2'b10: dec_rings = {4'h3, 4'h5};
            2'b11: dec_rings = {4'h4, 4'ha};
         endcase
   endfunction

   // Ticks.
   logic fine_tick;
   logic ms_tick;

   rda_tick #(
      .FINE_DIV(FINE_DIV),
      .MS_DIV(MS_DIV)
   ) u_tick (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .fine_tick(fine_tick),
      .ms_tick(ms_tick)
   );

   // Registers.
   logic [7:0] timing_sw_q;
   logic [7:0] modem_sw_q;
   logic [7:0] answer_sw_q;
   logic [7:0] ctrl_q;
   logic [`RDA_EV_W-1:0] irq_stat_q;
   logic [`RDA_EV_W-1:0] irq_en_q;

   // Ring state.
   logic sync1_q;
   logic sync2_q;
   logic ring_d_q;
   logic [`RDA_PER_W-1:0] per_q;
   logic in_band_q;
   logic [`RDA_MS_W-1:0] det_q;
   logic [`RDA_MS_W-1:0] off_q;
   logic gap_ok_q;
   logic [3:0] ring_cnt_q;
   logic answer_q;

   // Register decode.
   wire wr = bus_req.wr;
   wire [2:0] addr = bus_req.addr;
   wire [7:0] wdata = bus_req.wdata;
   wire wr_timing = wr & (addr == `RDA_REG_TIMING);
   wire wr_modem = wr & (addr == `RDA_REG_MODEM);
   wire wr_answer = wr & (addr == `RDA_REG_ANSWER);
   wire wr_ctrl = wr & (addr == `RDA_REG_CTRL);
   wire wr_clr = wr & (addr == `RDA_REG_IRQ_CLR);
   wire wr_en = wr & (addr == `RDA_REG_IRQ_EN);

   // Field selection.
   wire auto_en = ctrl_q[`RDA_CTRL_AUTO];
   wire force_lo = ctrl_q[`RDA_CTRL_REGION] & ~ctrl_q[`RDA_CTRL_PBX];
   wire limit_sw = ctrl_q[`RDA_CTRL_LIMIT];
   wire [3:0] delay = ctrl_q[`RDA_CTRL_DELAY_LSB+3:`RDA_CTRL_DELAY_LSB];
   wire [`RDA_MS_W-1:0] min_off = dec_min_off(timing_sw_q[1:0]);
   wire [`RDA_MS_W-1:0] max_off = dec_max_off(timing_sw_q[3:2]);
   wire [`RDA_MS_W-1:0] det_lim = dec_det(timing_sw_q[5:4]);
   wire [`RDA_PER_W-1:0] per_max =
      dec_per_max(answer_sw_q[1:0], force_lo);
   wire [`RDA_PER_W-1:0] per_min = dec_per_min(answer_sw_q[3:2]);
   wire [7:0] rings = dec_rings(answer_sw_q[7:4]);
   wire [3:0] ring_lo = rings[7:4];
   wire [3:0] ring_hi = rings[3:0];

   // The user delay is held inside the allowed range of the code.
   wire [3:0] target = (delay < ring_lo) ? ring_lo :
                       (delay > ring_hi) ? ring_hi : delay;

   // Frequency: the period between rising edges must fall inside the band.
   wire rise = sync2_q & ~ring_d_q;
   wire per_sat = (per_q == {`RDA_PER_W{1'b1}});
   wire per_in = (per_q >= per_min) & (per_q <= per_max);
   wire per_over = (per_q > per_max);
   wire band_rise = rise & per_in & ~in_band_q;
   wire in_band_d = rise ? per_in : (per_over ? 1'b0 : in_band_q);

   // Detecting and off timers on the millisecond tick.
   wire det_run = in_band_q & ms_tick & (det_q < det_lim);
   wire ack = det_run & (det_q + `RDA_MS_W'(1) == det_lim);
   wire off_run = ~in_band_q & ms_tick & (off_q < max_off);
   wire off_end = off_run & (off_q + `RDA_MS_W'(1) == max_off);
   wire gap_ok = (off_q > min_off) & (off_q < max_off);

   // Ring counting and answer decision.
   wire first = (ring_cnt_q == 4'h0);
   wire count = ack & (first | gap_ok_q) & (ring_cnt_q != 4'hf);
   wire timeout = off_end & ~first;
   wire [3:0] cnt_next = ring_cnt_q + 4'h1;
   wire answer_go = count & auto_en & ~answer_q & (cnt_next >= target);

   // Interrupt events; the set wins over a clear in the same cycle.
   wire [`RDA_EV_W-1:0] events = {timeout, answer_go, count, ack};
   wire [`RDA_EV_W-1:0] clr = wr_clr ? wdata[`RDA_EV_W-1:0] : '0;
   wire [`RDA_EV_W-1:0] irq_stat_d = (irq_stat_q & ~clr) | events;

   // Modem settings; attenuation steps weigh 8, 4, 2 and 1 dB.
   wire [3:0] atten_raw = {modem_sw_q[4], modem_sw_q[5],
                           modem_sw_q[6], modem_sw_q[7]};
   wire atten_cut = ~limit_sw & (atten_raw > `RDA_ATTEN_CAP);
   wire [3:0] atten = atten_cut ? `RDA_ATTEN_CAP : atten_raw;

   // Read data selection.
   wire [7:0] status = {1'b0, answer_q, gap_ok_q, in_band_q, ring_cnt_q};
   wire [7:0] rd_mux =
      (addr == `RDA_REG_TIMING) ? timing_sw_q :
      (addr == `RDA_REG_MODEM) ? modem_sw_q :
      (addr == `RDA_REG_ANSWER) ? answer_sw_q :
      (addr == `RDA_REG_CTRL) ? ctrl_q :
      (addr == `RDA_REG_STATUS) ? status :
      (addr == `RDA_REG_IRQ_STAT) ? {4'h0, irq_stat_q} :
      (addr == `RDA_REG_IRQ_EN) ? {4'h0, irq_en_q} : 8'h00;

   // Software registers.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         timing_sw_q <= `RDA_SW_RST;
         modem_sw_q <= `RDA_SW_RST;
         answer_sw_q <= `RDA_SW_RST;
         ctrl_q <= `RDA_CTRL_RST;
         irq_en_q <= '0;
      end
      else
      begin
         if (wr_timing)
            timing_sw_q <= wdata;
         if (wr_modem)
            modem_sw_q <= wdata;
         if (wr_answer)
            answer_sw_q <= wdata;
         if (wr_ctrl)
            ctrl_q <= wdata;
         if (wr_en)
            irq_en_q <= wdata[`RDA_EV_W-1:0];
      end
   end

   // Read data, interrupt status and line.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bus_rdata <= 8'h00;
         irq_stat_q <= '0;
         irq <= 1'b0;
      end
      else
      begin
         bus_rdata <= bus_req.rd ? rd_mux : 8'h00;
         irq_stat_q <= irq_stat_d;
         irq <= |(irq_stat_q & irq_en_q);
      end
   end

   // Ring pin synchroniser and edge memory.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         ring_d_q <= 1'b0;
      end
      else
      begin
         sync1_q <= ring_signal;
         sync2_q <= sync1_q;
         ring_d_q <= sync2_q;
      end
   end

   // Period measurement in fine ticks; saturation means no ringing.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         per_q <= {`RDA_PER_W{1'b1}};
         in_band_q <= 1'b0;
      end
      else
      begin
         if (rise)
            per_q <= '0;
         else if (fine_tick & ~per_sat)
            per_q <= per_q + `RDA_PER_W'(1);
         in_band_q <= in_band_d;
      end
   end

   // Detecting time restarts whenever in-band ringing drops out.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         det_q <= '0;
      else if (!in_band_q)
         det_q <= '0;
      else if (det_run)
         det_q <= det_q + `RDA_MS_W'(1);
   end

   // Off timer and the verdict on the gap that just ended.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         off_q <= '0;
         gap_ok_q <= 1'b0;
      end
      else
      begin
         if (in_band_q)
            off_q <= '0;
         else if (off_run)
            off_q <= off_q + `RDA_MS_W'(1);
         if (band_rise)
            gap_ok_q <= gap_ok;
      end
   end

   // Ring count and answer; a gap reaching the maximum ends the call.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ring_cnt_q <= 4'h0;
         answer_q <= 1'b0;
      end
      else
      begin
         if (timeout)
            ring_cnt_q <= 4'h0;
         else if (count)
            ring_cnt_q <= cnt_next;
         if (timeout)
            answer_q <= 1'b0;
         else if (answer_go)
            answer_q <= 1'b1;
      end
   end

   // Outputs to the modem and call handling.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         modem_cfg <= '0;
         automatic_answer <= 1'b0;
         ring_count <= 4'h0;
      end
      else
      begin
         modem_cfg.equalizer <= modem_sw_q[1:0];
         modem_cfg.rx_level <= modem_sw_q[3:2];
         modem_cfg.tx_atten <= atten;
         automatic_answer <= answer_q;
         ring_count <= ring_cnt_q;
      end
   end

endmodule // rda_top
`default_nettype wire

// [bench/rda_line_model.sv]
// Line-interface model that produces a digitised ringing waveform.
`timescale 1ns/1ps
`default_nettype none
module rda_line_model
#(
   parameter int HALF = 1000
)
(
   // Clock.
   input wire logic clk_sys,
   // Ringing request from the bench.
   input wire logic ring_on,
   // Digitised ringing towards the detector.
   output logic ring_signal = 1'b0
);
   int cnt = 0;
   // The detector output rests low between bursts.
   always @(posedge clk_sys)
   begin
      if (!ring_on)
      begin
         cnt <= 0;
         ring_signal <= 1'b0;
      end
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         ring_signal <= ~ring_signal;
      end
      else
         cnt <= cnt + 1;
   end
endmodule // rda_line_model
`default_nettype wire

// [bench/rda_asserts.sv]
// Concurrent checks on the ring detector ports.
`timescale 1ns/1ps
`default_nettype none
`include "rda_cfg.svh"
module rda_asserts
   import rda_pkg::*;
#(
   parameter int FINE_DIV = 5000
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register port.
   input wire rda_pkg::rda_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   // Line and modem.
   input wire logic ring_signal,
   input wire rda_pkg::rda_modem_t modem_cfg,
   // Call handling.
   input wire logic automatic_answer,
   input wire logic [3:0] ring_count,
   input wire logic irq
);
   // A qualified ring needs an edge within the slowest band period.
   localparam int QUIET_MAX = 810 * FINE_DIV + 10;
   logic [7:0] mdm_q;
   logic [7:0] ctl_q;
   logic [1:0] settle_q;
   logic [31:0] quiet_q;
   logic ring_d_q;
   wire mdm_wr = bus_req.wr && bus_req.addr == `RDA_REG_MODEM;
   wire ctl_wr = bus_req.wr && bus_req.addr == `RDA_REG_CTRL;
   wire [3:0] sum_w = {mdm_q[4], mdm_q[5], mdm_q[6], mdm_q[7]};
   wire cap_w = !ctl_q[`RDA_CTRL_LIMIT] && sum_w > `RDA_ATTEN_CAP;
   wire [3:0] atten_w = cap_w ? `RDA_ATTEN_CAP : sum_w;
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mdm_q <= `RDA_SW_RST;
         ctl_q <= `RDA_CTRL_RST;
         settle_q <= 2'h0;
         quiet_q <= 32'h0;
         ring_d_q <= 1'b0;
      end
      else
      begin
         mdm_q <= mdm_wr ? bus_req.wdata : mdm_q;
         ctl_q <= ctl_wr ? bus_req.wdata : ctl_q;
         settle_q <= (mdm_wr || ctl_wr) ? 2'h0 :
            settle_q + {1'b0, settle_q != 2'h3};
         ring_d_q <= ring_signal;
         quiet_q <= (ring_signal != ring_d_q) ? 32'h0 :
            quiet_q + {31'h0, !quiet_q[31]};
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   a_eq_code: assert property (
      settle_q == 2'h3 |-> modem_cfg.equalizer == mdm_q[1:0])
      else $error("equalizer code differs from setting");
   a_rx_code: assert property (
      settle_q == 2'h3 |-> modem_cfg.rx_level == mdm_q[3:2])
      else $error("reception level code differs from setting");
   a_atten_sum: assert property (
      settle_q == 2'h3 |-> modem_cfg.tx_atten == atten_w)
      else $error("attenuation sum wrong");
   a_atten_cap: assert property (
      !$past(ctl_q[`RDA_CTRL_LIMIT]) |-> modem_cfg.tx_atten <= `RDA_ATTEN_CAP)
      else $error("attenuation above cap while limited");
   a_reset_clear: assert property (
      $rose(reset_n) |-> ring_count == 4'h0 && !automatic_answer)
      else $error("call state not clear after reset");
   a_count_step: assert property (
      $changed(ring_count) && ring_count != 4'h0 |->
         ring_count == $past(ring_count) + 4'h1)
      else $error("ring count jumped");
   a_count_quiet: assert property (
      $changed(ring_count) && ring_count != 4'h0 |-> quiet_q < QUIET_MAX)
      else $error("ring counted without ringing");
   a_ans_count: assert property (
      $rose(automatic_answer) |-> ring_count != 4'h0)
      else $error("answer without counted ring");
   a_ans_enable: assert property (
      $rose(automatic_answer) |-> ctl_q[`RDA_CTRL_AUTO])
      else $error("answer while auto answer off");
   a_rdata_idle: assert property (
      !$past(bus_req.rd) |-> bus_rdata == 8'h00)
      else $error("read data outside read slot");
   c_two_rings: cover property (ring_count == 4'h2);
   c_answer: cover property ($rose(automatic_answer));
   c_irq: cover property ($rose(irq));
endmodule // rda_asserts
bind rda_top rda_asserts #(.FINE_DIV(FINE_DIV)) u_asserts (.clk_sys(clk_sys),
   .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .ring_signal(ring_signal), .modem_cfg(modem_cfg),
   .automatic_answer(automatic_answer), .ring_count(ring_count), .irq(irq));
`default_nettype wire

// [bench/test_rda_top.sv]
// Self-checking bench for ring detection and modem setting decode.
`timescale 1ns/1ps
`default_nettype none
`include "rda_cfg.svh"
module test_rda_top;
   import rda_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   rda_req_t bus_req = '0;
   logic [7:0] bus_rdata;
   logic ring_signal;
   logic ring_on = 1'b0;
   rda_modem_t modem_cfg;
   logic automatic_answer;
   logic [3:0] ring_count;
   logic irq;
   int num_errors = 0;
   int checked = 0;
   always #10 clk_sys = ~clk_sys;
   rda_top #(.FINE_DIV(5), .MS_DIV(10)) u_dut (.clk_sys(clk_sys),
      .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .ring_signal(ring_signal), .modem_cfg(modem_cfg),
      .automatic_answer(automatic_answer), .ring_count(ring_count), .irq(irq));
   // A half period of 1000 clocks gives 25 Hz ringing with the short ticks.
   rda_line_model #(.HALF(1000)) u_line (.clk_sys(clk_sys), .ring_on(ring_on),
      .ring_signal(ring_signal));
   task automatic test_done();
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req <= '0;
      #1 d = bus_rdata;
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask
   task automatic ring(input int n);
      ring_on <= 1'b1;
      wait_clk(n);
      ring_on <= 1'b0;
   endtask
   task automatic t_regs();
      rd_chk(`RDA_REG_TIMING, `RDA_SW_RST);
      rd_chk(`RDA_REG_ANSWER, `RDA_SW_RST);
      rd_chk(`RDA_REG_CTRL, `RDA_CTRL_RST);
      rd_chk(`RDA_REG_IRQ_EN, 8'h00);
      wr_reg(`RDA_REG_IRQ_STAT, 8'hff);
      rd_chk(`RDA_REG_IRQ_STAT, 8'h00);
      rd_chk(`RDA_REG_IRQ_CLR, 8'h00);
      wr_reg(`RDA_REG_TIMING, 8'h25);
      rd_chk(`RDA_REG_TIMING, 8'h25);
   endtask
   task automatic t_modem();
      logic [7:0] vals [7] = '{8'h1b, 8'hf6, 8'h10, 8'h20,
                               8'h40, 8'h80, 8'hc4};
      logic [3:0] e;
      for (int lim = 0; lim < 2; lim++)
      begin
         wr_reg(`RDA_REG_CTRL, lim ? 8'h08 : 8'h00);
         foreach (vals[i])
         begin
            wr_reg(`RDA_REG_MODEM, vals[i]);
            wait_clk(4);
            e = {vals[i][4], vals[i][5], vals[i][6], vals[i][7]};
            if (lim == 0 && e > 4'h8)
               e = 4'h8;
            chk(modem_cfg, {vals[i][1:0], vals[i][3:2], e});
         end
      end
      rd_chk(`RDA_REG_MODEM, 8'hc4);
   endtask
   task automatic t_ring();
      // Minimum gap 500 ms, detect 150 ms, band 23 to 30 Hz, fixed 2 rings.
      wr_reg(`RDA_REG_TIMING, 8'h31);
      wr_reg(`RDA_REG_ANSWER, 8'h12);
      wr_reg(`RDA_REG_IRQ_EN, 8'h02);
      wr_reg(`RDA_REG_CTRL, 8'h09);
      ring(12000);
      wait_clk(10);
      chk({4'h0, ring_count}, 8'h01);
      chk({7'h0, automatic_answer}, 8'h00);
      chk({7'h0, irq}, 8'h01);
      rd_chk(`RDA_REG_IRQ_STAT, 8'h03);
      wr_reg(`RDA_REG_IRQ_CLR, 8'h0f);
      wait_clk(2);
      chk({7'h0, irq}, 8'h00);
      wr_reg(`RDA_REG_IRQ_EN, 8'h00);
      wait_clk(27000);
      ring(12000);
      wait_clk(10);
      chk({4'h0, ring_count}, 8'h02);
      chk({7'h0, automatic_answer}, 8'h01);
      chk({7'h0, irq}, 8'h00);
      wr_reg(`RDA_REG_IRQ_EN, 8'h02);
      wait_clk(2);
      chk({7'h0, irq}, 8'h01);
      rd_chk(`RDA_REG_IRQ_STAT, 8'h07);
      rd_chk(`RDA_REG_STATUS, 8'h72);
   endtask
   task automatic t_region();
      logic [7:0] d;
      wr_reg(`RDA_REG_CTRL, 8'h0b);
      ring(6000);
      rd_reg(`RDA_REG_STATUS, d);
      chk(d & 8'h10, 8'h00);
      rd_chk(`RDA_REG_ANSWER, 8'h12);
      wr_reg(`RDA_REG_CTRL, 8'h0f);
      ring(6000);
      rd_reg(`RDA_REG_STATUS, d);
      chk(d & 8'h10, 8'h10);
   endtask
   initial
   begin
      wait_clk(8);
      reset_n <= 1'b1;
      t_regs();
      t_modem();
      t_ring();
      t_region();
      test_done();
   end
   initial
   begin
      wait_clk(90000);
      num_errors++;
      test_done();
   end
endmodule // test_rda_top
`default_nettype wire
